// ==== inc/event_fifo_if.sv ====
`default_nettype none
interface event_fifo_if #(parameter int W = 7);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport source (output push_valid, output push_data, input push_ready);
  modport sink (input pop_valid, input pop_data, output pop_ready);
  modport store (input push_valid, input push_data, input pop_ready,
                 output push_ready, output pop_valid, output pop_data);
endinterface
`default_nettype wire

// ==== inc/s2p_pkg.sv ====
`default_nettype none
package s2p_pkg;
  // Geometry of the shift chains
  localparam int CHAINS = 4;
  localparam int CHAIN_LEN = 8;
  // Event buffer between the pin sampler and the shift engine
  localparam int FIFO_DEPTH = 16;
  // Core cycles between two events drained from the buffer
  localparam int DRAIN_DIV = 2;
  localparam int DIV_W = 8;
  // Layout of one buffered event word
  localparam int EV_LE = 0;
  localparam int EV_DATA_LSB = 1;
  localparam int EV_DIR = 5;
  localparam int EV_SHIFT = 6;
  localparam int EV_W = 7;
  // Positions in the open-pin vector
  localparam int PIN_SCLK = 0;
  localparam int PIN_DATA_LSB = 1;
  localparam int PIN_DIR = 5;
  localparam int PIN_LE = 6;
  localparam int PIN_OE = 7;
  localparam int PIN_N = 8;
  // Values after reset
  localparam logic [31:0] CHAIN_RST = 32'h0000_0000;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  localparam logic [3:0] SOUT_RST = 4'h0;
  localparam logic DIR_RST = 1'b1;
endpackage
`default_nettype wire

// ==== rtl/serial_to_parallel_latch.sv ====
`default_nettype none
module serial_to_parallel_latch
  import s2p_pkg::*;
#(
  parameter int NUM_CHAINS = CHAINS,
  parameter int STAGES = CHAIN_LEN,
  parameter int BUF_DEPTH = FIFO_DEPTH,
  parameter int DRAIN_CYCLES = DRAIN_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic [3:0] serial_in,
  input wire logic shift_dir,
  input wire logic latch_transfer_gate,
  input wire logic output_enable,
  input wire logic [PIN_N-1:0] pin_open,
  output logic [31:0] driver_output,
  output logic [3:0] serial_out,
  output logic event_ready
);
  localparam int NBITS = NUM_CHAINS * STAGES;

  // The event word and output widths are fixed at four chains of eight
  initial
  begin
    if (NUM_CHAINS != CHAINS || STAGES != CHAIN_LEN)
      $error("serial_to_parallel_latch: only 4 chains of 8 stages are supported");
    if (DRAIN_CYCLES < 1 || DRAIN_CYCLES > 255)
      $error("serial_to_parallel_latch: DRAIN_CYCLES out of range");
  end

  // Open pin floats high through the pull-up
  function automatic logic pin_level(input logic pin, input logic open_pin);
    pin_level = pin | open_pin;
  endfunction

  // One stage of one chain; forward enters at stage 0, reverse at the top
  function automatic logic [STAGES-1:0] shift_one(input logic [STAGES-1:0] cur,
                                                  input logic din, input logic fwd);
    if (fwd)
      shift_one = {cur[STAGES-2:0], din};
    else
      shift_one = {din, cur[STAGES-1:1]};
  endfunction

  logic sclk_eff, dir_eff, le_eff, oe_eff;
  logic [3:0] din_eff;
  logic sclk_rise, le_change, push_fire, pop_fire, drain_tick;
  logic [EV_W-1:0] ev;

  event_fifo_if #(.W(EV_W)) evq ();

  // Resolve every logic input through its pull-up
  always_comb
  begin
    sclk_eff = pin_level(shift_clk, pin_open[PIN_SCLK]);
    dir_eff = pin_level(shift_dir, pin_open[PIN_DIR]);
    le_eff = pin_level(latch_transfer_gate, pin_open[PIN_LE]);
    oe_eff = pin_level(output_enable, pin_open[PIN_OE]);
    for (int i = 0; i < 4; i++)
      din_eff[i] = pin_level(serial_in[i], pin_open[PIN_DATA_LSB + i]);
  end

  // Sampler state: last clock level and last latch level sent on
  logic sclk_prev_q, sclk_prev_d, le_prev_q, le_prev_d;

  always_comb
  begin
    sclk_rise = sclk_eff & ~sclk_prev_q;
    le_change = le_eff ^ le_prev_q;
    sclk_prev_d = sclk_eff;
    // A latch change refused by a full buffer is offered again next cycle
    le_prev_d = push_fire ? le_eff : le_prev_q;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b1;
      le_prev_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      le_prev_q <= le_prev_d;
    end
  end

  // A rising edge or latch change becomes one ordered event; a rising edge refused by a full buffer is lost
  assign ev[EV_SHIFT] = sclk_rise;
  assign ev[EV_DIR] = dir_eff;
  assign ev[EV_DATA_LSB +: 4] = din_eff;
  assign ev[EV_LE] = le_eff;
  assign evq.push_valid = sclk_rise | le_change;
  assign evq.push_data = ev;
  assign push_fire = evq.push_valid & evq.push_ready;

  word_fifo #(.WIDTH(EV_W), .DEPTH(BUF_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .q(evq.store)
  );

  // Drain pacing; a slow drain lets a burst of events back up in the buffer
  logic [DIV_W-1:0] div_q, div_d;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DRAIN_CYCLES - 1);

  always_comb
  begin
    drain_tick = (div_q == DIV_LAST);
    div_d = drain_tick ? '0 : DIV_W'(div_q + 1'b1);
  end

  assign evq.pop_ready = drain_tick;
  assign pop_fire = evq.pop_valid & drain_tick;

  // Shift engine, latches and registered outputs
  logic [NBITS-1:0] chain_q, chain_d, latch_q, latch_d;
  logic gate_q, gate_d, dir_q, dir_d, ready_d;
  logic [31:0] drv_d;
  logic [3:0] sout_d;
  logic [EV_W-1:0] pe;

  assign pe = evq.pop_data;

  always_comb
  begin
    chain_d = chain_q;
    gate_d = gate_q;
    dir_d = dir_q;
    if (pop_fire)
    begin
      gate_d = pe[EV_LE];
      // Shift does not look at the latch level at all
      if (pe[EV_SHIFT])
      begin
        dir_d = pe[EV_DIR];
        for (int c = 0; c < NUM_CHAINS; c++)
          chain_d[c*STAGES +: STAGES] = shift_one(chain_q[c*STAGES +: STAGES],
                                                  pe[EV_DATA_LSB + c], pe[EV_DIR]);
      end
    end
    latch_d = gate_d ? chain_d : latch_q;
    drv_d = oe_eff ? latch_q : '0;
    for (int c = 0; c < NUM_CHAINS; c++)
      sout_d[c] = dir_d ? chain_d[c*STAGES + STAGES - 1] : chain_d[c*STAGES];
    ready_d = evq.push_ready;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
      chain_q <= CHAIN_RST;
      latch_q <= LATCH_RST;
      gate_q <= 1'b0;
      dir_q <= DIR_RST;
      driver_output <= LATCH_RST;
      serial_out <= SOUT_RST;
      event_ready <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      chain_q <= chain_d;
      latch_q <= latch_d;
      gate_q <= gate_d;
      dir_q <= dir_d;
      driver_output <= drv_d;
      serial_out <= sout_d;
      event_ready <= ready_d;
    end
  end

  // Checks on the sampler
  a_rise_queued: assert property (
    @(posedge core_clk) disable iff (rst)
    (sclk_eff && !sclk_prev_q && evq.push_ready) |-> push_fire && ev[EV_SHIFT])
    else $error("rising shift clock edge not queued");
  a_fall_ignored: assert property (
    @(posedge core_clk) disable iff (rst)
    (!sclk_eff && sclk_prev_q && !le_change) |-> !evq.push_valid)
    else $error("falling shift clock edge produced an event");
  a_idle_stable: assert property (
    @(posedge core_clk) disable iff (rst)
    !pop_fire |=> $stable(chain_q))
    else $error("chains moved without a shift event");

  // Checks on shifting
  a_fwd_shift: assert property (
    @(posedge core_clk) disable iff (rst)
    (pop_fire && pe[EV_SHIFT] && pe[EV_DIR]) |=>
      chain_q[0] == $past(pe[EV_DATA_LSB]) && chain_q[7:1] == $past(chain_q[6:0]))
    else $error("forward shift wrong");
  a_rev_shift: assert property (
    @(posedge core_clk) disable iff (rst)
    (pop_fire && pe[EV_SHIFT] && !pe[EV_DIR]) |=>
      chain_q[7] == $past(pe[EV_DATA_LSB]) && chain_q[6:0] == $past(chain_q[7:1]))
    else $error("reverse shift wrong");
  a_last_chain: assert property (
    @(posedge core_clk) disable iff (rst)
    (pop_fire && pe[EV_SHIFT]) |=>
      (dir_q ? chain_q[24] : chain_q[31]) == $past(pe[EV_DATA_LSB + 3]))
    else $error("chain 3 did not shift with chain 0");
  a_shift_low_le: assert property (
    @(posedge core_clk) disable iff (rst)
    (pop_fire && pe[EV_SHIFT] && !pe[EV_LE] && pe[EV_DIR]) |=>
      chain_q[7:1] == $past(chain_q[6:0]))
    else $error("shift blocked by low latch level");

  // Checks on latches and outputs
  a_latch_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    gate_q |-> latch_q == chain_q)
    else $error("latches not following chains");
  a_latch_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !gate_q |-> $stable(latch_q))
    else $error("latches changed while closed");
  a_out_gated: assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> driver_output == ($past(oe_eff) ? $past(latch_q) : 32'h0000_0000))
    else $error("driver output not latch through enable");
  a_open_enable: assert property (
    @(posedge core_clk) disable iff (rst)
    (pin_open[PIN_OE] && !output_enable) |=> driver_output == $past(latch_q))
    else $error("open enable pin not read high");
  a_cascade_out: assert property (
    @(posedge core_clk) disable iff (rst)
    serial_out[0] == (dir_q ? chain_q[7] : chain_q[0]))
    else $error("serial output not the exiting stage");
endmodule
`default_nettype wire

// ==== rtl/word_fifo.sv ====
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  event_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] cnt_t;
  typedef logic [AW-1:0] ptr_t;
  localparam cnt_t FULL_CNT = cnt_t'(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("word_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  ptr_t wr_q, wr_d, rd_q, rd_d;
  cnt_t count_q, count_d;
  logic push_fire, pop_fire;

  // Honest full and empty straight from the held count
  assign q.push_ready = (count_q != FULL_CNT);
  assign q.pop_valid = (count_q != '0);
  assign q.pop_data = mem_q[rd_q];
  assign push_fire = q.push_valid & q.push_ready;
  assign pop_fire = q.pop_valid & q.pop_ready;

  // Next pointers and occupancy
  always_comb
  begin
    wr_d = push_fire ? ptr_t'(wr_q + 1'b1) : wr_q;
    rd_d = pop_fire ? ptr_t'(rd_q + 1'b1) : rd_q;
    count_d = count_q;
    if (push_fire && !pop_fire)
      count_d = cnt_t'(count_q + 1'b1);
    else if (pop_fire && !push_fire)
      count_d = cnt_t'(count_q - 1'b1);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
    end
  end

  // Storage needs no reset; nothing is read before it is written
  always_ff @(posedge core_clk)
  begin
    if (push_fire)
      mem_q[wr_q] <= q.push_data;
  end

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (rst)
    count_q <= FULL_CNT)
    else $error("fifo count above depth");
  a_fifo_count: assert property (@(posedge core_clk) disable iff (rst)
    (push_fire && !pop_fire) |=> count_q == cnt_t'($past(count_q) + 1'b1))
    else $error("fifo count did not rise on push");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`default_nettype none
module host_model
  import s2p_pkg::*;
(
  input wire logic core_clk,
  output logic shift_clk,
  output logic [3:0] serial_in,
  output logic shift_dir,
  output logic latch_transfer_gate
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle host: clock low, direction forward, gate closed
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 4'h0;
    shift_dir = 1'b1;
    latch_transfer_gate = 1'b0;
  end

  // Every change lands just after a core clock edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Eight bits per chain, first bit sent is bit 7 of each byte
  task automatic load(input logic dir, input logic [31:0] pat, input int half);
    int b;
    int c;
    shift_dir = dir;
    for (b = 7; b >= 0; b--)
    begin
      for (c = 0; c < 4; c++)
        serial_in[c] = pat[c*8+b];
      step(half);
      shift_clk = 1'b1;
      step(half);
      shift_clk = 1'b0;
      // Hold time is over, so the data is no longer worth trusting
      serial_in = ~serial_in;
      step(1);
    end
  endtask

  // One gate pulse after a complete load
  task automatic pulse_latch(input int half);
    latch_transfer_gate = 1'b1;
    step(half);
    latch_transfer_gate = 1'b0;
    step(half);
  endtask
endmodule
`default_nettype wire

// ==== tb/serial_to_parallel_latch_tb.sv ====
`default_nettype none
module serial_to_parallel_latch_tb
  import s2p_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst;
  logic shift_clk;
  logic [3:0] serial_in;
  logic shift_dir;
  logic latch_transfer_gate;
  logic output_enable;
  logic [PIN_N-1:0] pin_open;
  logic [31:0] driver_output;
  logic [3:0] serial_out;
  logic event_ready;
  logic [31:0] latched = 32'h0;
  logic saw_full = 1'b0;
  logic [35:0] exp_q[$];
  int seed = 50;
  int n_errors = 0;
  int checked = 0;
  int k;
  event sample_ev;

  always #5 core_clk = ~core_clk;

  host_model i_host (.core_clk(core_clk), .shift_clk(shift_clk), .serial_in(serial_in),
    .shift_dir(shift_dir), .latch_transfer_gate(latch_transfer_gate));

  // Slow drain so a fast burst can overrun the buffer
  serial_to_parallel_latch #(.DRAIN_CYCLES(8)) i_dut (.core_clk(core_clk), .rst(rst),
    .shift_clk(shift_clk), .serial_in(serial_in), .shift_dir(shift_dir),
    .latch_transfer_gate(latch_transfer_gate), .output_enable(output_enable),
    .pin_open(pin_open), .driver_output(driver_output), .serial_out(serial_out),
    .event_ready(event_ready));

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Chain c stage s sits at bit c*8+s; open data pins read as ones
  function automatic logic [31:0] arrange(input logic dir, input logic [31:0] pat);
    logic [31:0] r;
    int c;
    int s;
    for (c = 0; c < 4; c++)
      for (s = 0; s < 8; s++)
        r[c*8+s] = pin_open[PIN_DATA_LSB+c] ? 1'b1 : (dir ? pat[c*8+s] : pat[c*8+7-s]);
    return r;
  endfunction

  task automatic note(input logic [31:0] drv, input logic [3:0] so);
    exp_q.push_back({drv, so});
    -> sample_ev;
  endtask

  // Load, optionally latch, then note what the pins must show
  task automatic frame(input logic dir, input logic [31:0] pat, input logic do_latch);
    logic edir;
    logic [31:0] r;
    logic [3:0] so;
    int c;
    edir = dir | pin_open[PIN_DIR];
    r = arrange(edir, pat);
    for (c = 0; c < 4; c++)
      so[c] = edir ? r[c*8+7] : r[c*8];
    i_host.load(dir, pat, 5);
    if (do_latch)
      i_host.pulse_latch(5);
    i_host.step(30);
    if (do_latch | pin_open[PIN_LE])
      latched = r;
    note((output_enable | pin_open[PIN_OE]) ? latched : 32'h0, so);
  endtask

  // Watcher compares the oldest note once outputs have settled
  always @(sample_ev)
  begin
    check("outputs", {driver_output, serial_out}, exp_q.pop_front());
    // A quiet host must never find the buffer full
    check("ready", event_ready, 1'b1);
  end

  // Remembers any refusal seen during a burst
  always @(posedge core_clk)
    if (!rst && event_ready === 1'b0)
      saw_full <= 1'b1;

  initial
  begin
    rst = 1'b1;
    output_enable = 1'b1;
    pin_open = 8'h00;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    i_host.step(3);
    note(32'h0, 4'h0);
    // Both directions with random patterns and a random enable level
    for (k = 0; k < 6; k++)
    begin
      output_enable = 1'($random(seed));
      frame(k[0], $random(seed), 1'b1);
    end
    output_enable = 1'b1;
    // No gate pulse: chains move, latches hold
    frame(1'b1, $random(seed), 1'b0);
    output_enable = 1'b0;
    frame(1'b0, $random(seed), 1'b1);
    pin_open[PIN_OE] = 1'b1;
    frame(1'b1, $random(seed), 1'b0);
    output_enable = 1'b1;
    // Only the direction pin open
    pin_open = 8'h20;
    frame(1'b0, $random(seed), 1'b1);
    // Open data pins and open gate: ones shift in while latches follow
    pin_open = 8'h5e;
    frame(1'b0, $random(seed), 1'b0);
    pin_open = 8'h00;
    // Fast burst overruns the buffer
    saw_full = 1'b0;
    for (k = 0; k < 5; k++)
      i_host.load(1'b1, $random(seed), 1);
    check("refusal", saw_full, 1'b1);
    for (k = 0; k < 400 && event_ready !== 1'b1; k++)
      i_host.step(1);
    if (event_ready !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
    i_host.step(150);
    // A full load afterwards restores a known pattern
    frame(1'b0, $random(seed), 1'b1);
    // Reset in mid-run; one idle edge first so the last note sees settled outputs
    i_host.step(1);
    rst = 1'b1;
    latched = 32'h0;
    i_host.step(2);
    rst = 1'b0;
    i_host.step(3);
    note(32'h0, 4'h0);
    // The block must load and latch normally after that reset
    frame(1'b1, $random(seed), 1'b1);
    i_host.step(5);
    give_verdict();
  end
endmodule
`default_nettype wire
